// File: design/vmr_pkg.sv
// Package with object indices, field positions and types of the velocity-mode objects.
package vmr_pkg;

  // Object dictionary indices.
  localparam logic [15:0] IDX_CONTROL_WORD   = 16'h6040;
  localparam logic [15:0] IDX_TARGET_SPEED   = 16'h6042;
  localparam logic [15:0] IDX_RAMPED_DEMAND  = 16'h6043;
  localparam logic [15:0] IDX_MEASURED_SPEED = 16'h6044;
  localparam logic [15:0] IDX_SPEED_LIMITS   = 16'h6046;
  localparam logic [15:0] IDX_ACCEL_RECORD   = 16'h6048;

  // Sub-indices of the array and record objects.
  localparam logic [7:0]  SUB_COUNT  = 8'h00;
  localparam logic [7:0]  SUB_FIRST  = 8'h01;
  localparam logic [7:0]  SUB_SECOND = 8'h02;
  localparam logic [31:0] LAST_SUB_INDEX = 32'h0000_0002;

  // Control word bit positions used in velocity mode.
  localparam int CW_RESERVED_A  = 4;
  localparam int CW_RESERVED_B  = 5;
  localparam int CW_REF_RAMP    = 6;
  localparam int CW_HALT        = 8;

  // CAN control parameter word bit positions.
  localparam int CP_RAMP_ENABLE = 0;
  localparam int CP_REVERSE     = 2;

  // Reset values, the speed magnitude limit and the fixed mode status bits.
  localparam logic [15:0] TARGET_SPEED_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_WORD_RESET = 16'h0000;
  localparam logic [31:0] SPEED_MIN_RESET    = 32'h0000_0000;
  localparam logic [31:0] SPEED_MAX_RESET    = 32'h0000_7fff;
  localparam logic [31:0] DELTA_SPEED_RESET  = 32'h0000_0001;
  localparam logic [31:0] DELTA_TIME_RESET   = 32'h0000_0001;
  localparam logic [15:0] SPEED_MAG_LIMIT    = 16'h7fff;
  localparam logic [1:0]  MODE_STATUS_BITS   = 2'b00;

  // Ramp time base: delta time is counted in units of this period.
  localparam int CLK_MHZ        = 250;
  localparam int RAMP_TICK_US   = 1000;
  localparam int RAMP_TICK_CYC  = RAMP_TICK_US * CLK_MHZ;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] wdata;
  } vmr_req_t;

  typedef struct packed {
    logic        ack;
    logic        error;
    logic [31:0] rdata;
  } vmr_rsp_t;

endpackage

// File: design/vmr_velocity_mode.sv
// Velocity-mode objects: control bits, target, ramp, limits and speed readback.
`timescale 1ns/1ps
module vmr_velocity_mode
  import vmr_pkg::*;
#(
  parameter int TICK_CYCLES = RAMP_TICK_CYC
)
(
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire vmr_pkg::vmr_req_t   obj_req,
  output      vmr_pkg::vmr_rsp_t   obj_rsp,
  input  wire logic [15:0]         motor_speed_param,
  input  wire logic                speed_feedback_present,
  output      logic [15:0]         can_control_param_word,
  output      logic [15:0]         can_speed_ref_param,
  output      logic [15:0]         ramped_speed_demand,
  output      logic [1:0]          status_mode_bits
);
  import vmr_pkg::*;

  typedef struct packed {
    logic [15:0] control_word;
    logic [15:0] target_speed_reference;
    logic [31:0] speed_limit_minimum;
    logic [31:0] speed_limit_maximum;
    logic [31:0] accel_delta_speed;
    logic [31:0] accel_delta_time;
    logic [15:0] demand;
    logic [31:0] accum;
    logic [31:0] tick_cnt;
    logic [15:0] param_word;
    logic [15:0] speed_ref;
    vmr_rsp_t    rsp;
  } vmr_state_t;

  vmr_state_t  state;
  vmr_state_t  next_state;

  logic        ramp_enable;
  logic        reverse;
  logic [15:0] target_mag;
  logic [15:0] clamp_mag;
  logic [15:0] min_mag;
  logic [15:0] max_mag;
  logic [15:0] goal;
  logic        tick;
  logic [32:0] accum_sum;
  logic [32:0] accum_left;
  logic [15:0] measured;

  // Bits 4 and 5 are never read here, so they carry no function.
  // The master's bit 4 run request is therefore accepted and ignored.
  assign ramp_enable = state.control_word[CW_REF_RAMP]
                     & ~state.control_word[CW_HALT];

  assign reverse = state.target_speed_reference[15];

  // Magnitude of the requested speed, saturated to the 15-bit range (SPEED_MAG_LIMIT).
  always_comb
  begin
    if (reverse)
    begin
      target_mag = 16'(-state.target_speed_reference);
      if (target_mag[15])
      begin
        target_mag = SPEED_MAG_LIMIT;
      end
    end
    else
    begin
      target_mag = state.target_speed_reference;
    end
  end

  // Limits are magnitudes, so they apply alike in both directions.
  always_comb
  begin
    if (state.speed_limit_minimum > {16'h0000, SPEED_MAG_LIMIT})
    begin
      min_mag = SPEED_MAG_LIMIT;
    end
    else
    begin
      min_mag = state.speed_limit_minimum[15:0];
    end
    if (state.speed_limit_maximum > {16'h0000, SPEED_MAG_LIMIT})
    begin
      max_mag = SPEED_MAG_LIMIT;
    end
    else
    begin
      max_mag = state.speed_limit_maximum[15:0];
    end
  end

  // A zero request stays zero; otherwise clamp into [min, max].
  always_comb
  begin
    if (target_mag == 16'h0000)
    begin
      clamp_mag = 16'h0000;
    end
    else if (target_mag > max_mag)
    begin
      clamp_mag = max_mag;
    end
    else if (target_mag < min_mag)
    begin
      clamp_mag = min_mag;
    end
    else
    begin
      clamp_mag = target_mag;
    end
  end

  // With the ramp-enable bit clear the demand is taken down to zero.
  always_comb
  begin
    if (!ramp_enable)
    begin
      goal = 16'h0000;
    end
    else if (reverse)
    begin
      goal = 16'(-clamp_mag);
    end
    else
    begin
      goal = clamp_mag;
    end
  end

  assign tick      = (state.tick_cnt == 32'(TICK_CYCLES - 1));
  assign accum_sum = {1'b0, state.accum} + {1'b0, state.accel_delta_speed};
  assign accum_left = accum_sum - {1'b0, state.accel_delta_time};

  // Without a feedback source the demand stands in for the measured speed.
  assign measured = speed_feedback_present ? motor_speed_param
                                           : state.demand;

  always_comb
  begin
    next_state           = state;
    next_state.rsp.ack   = 1'b0;
    next_state.rsp.error = 1'b0;

    if (tick)
    begin
      next_state.tick_cnt = 32'h0000_0000;
    end
    else
    begin
      next_state.tick_cnt = state.tick_cnt + 32'h0000_0001;
    end

    // Each time-base tick adds delta speed to the accumulator; every
    // delta time worth taken out moves the demand one rpm, so the rate
    // is delta speed over delta time in rpm per tick.
    if (state.demand == goal)
    begin
      next_state.accum = 32'h0000_0000;
    end
    else if (state.accel_delta_time == 32'h0000_0000)
    begin
      next_state.demand = goal;
      next_state.accum  = 32'h0000_0000;
    end
    else if (state.accum >= state.accel_delta_time)
    begin
      // A tick that lands on a step still adds its delta speed, so the
      // rate holds even when one tick's worth fills a whole tick; above that the demand moves one rpm per cycle.
      if (tick)
      begin
        next_state.accum = accum_left[32] ? 32'hffff_ffff
                                          : accum_left[31:0];
      end
      else
      begin
        next_state.accum = state.accum - state.accel_delta_time;
      end
      if ($signed(state.demand) < $signed(goal))
      begin
        next_state.demand = state.demand + 16'h0001;
      end
      else
      begin
        next_state.demand = state.demand - 16'h0001;
      end
    end
    else if (tick)
    begin
      next_state.accum = accum_sum[32] ? 32'hffff_ffff
                                       : accum_sum[31:0];
    end

    next_state.param_word                 = 16'h0000;
    next_state.param_word[CP_RAMP_ENABLE] = ramp_enable;
    next_state.param_word[CP_REVERSE]     = reverse;
    next_state.speed_ref                  = clamp_mag;

    if (obj_req.valid)
    begin
      next_state.rsp.ack   = 1'b1;
      next_state.rsp.rdata = 32'h0000_0000;
      if (obj_req.index == IDX_CONTROL_WORD
          && obj_req.subindex == SUB_COUNT)
      begin
        next_state.rsp.rdata = {16'h0000, state.control_word};
        if (obj_req.write)
        begin
          next_state.control_word = obj_req.wdata[15:0];
        end
      end
      else if (obj_req.index == IDX_TARGET_SPEED
               && obj_req.subindex == SUB_COUNT)
      begin
        next_state.rsp.rdata = {{16{state.target_speed_reference[15]}},
                                state.target_speed_reference};
        if (obj_req.write)
        begin
          next_state.target_speed_reference = obj_req.wdata[15:0];
        end
      end
      else if (obj_req.index == IDX_RAMPED_DEMAND
               && obj_req.subindex == SUB_COUNT)
      begin
        next_state.rsp.rdata = {{16{state.demand[15]}}, state.demand};
        next_state.rsp.error = obj_req.write;
      end
      else if (obj_req.index == IDX_MEASURED_SPEED
               && obj_req.subindex == SUB_COUNT)
      begin
        next_state.rsp.rdata = {{16{measured[15]}}, measured};
        next_state.rsp.error = obj_req.write;
      end
      else if (obj_req.index == IDX_SPEED_LIMITS)
      begin
        if (obj_req.subindex == SUB_COUNT)
        begin
          next_state.rsp.rdata = LAST_SUB_INDEX;
          next_state.rsp.error = obj_req.write;
        end
        else if (obj_req.subindex == SUB_FIRST
                 || obj_req.subindex == SUB_SECOND)
        begin
          next_state.rsp.rdata = (obj_req.subindex == SUB_FIRST)
                                 ? state.speed_limit_minimum
                                 : state.speed_limit_maximum;
          // Zero or values with the top bit set are not positive.
          if (obj_req.write && (obj_req.wdata == 32'h0000_0000
                                || obj_req.wdata[31]))
          begin
            next_state.rsp.error = 1'b1;
          end
          else if (obj_req.write && obj_req.subindex == SUB_FIRST)
          begin
            next_state.speed_limit_minimum = obj_req.wdata;
          end
          else if (obj_req.write)
          begin
            next_state.speed_limit_maximum = obj_req.wdata;
          end
        end
        else
        begin
          next_state.rsp.error = 1'b1;
        end
      end
      else if (obj_req.index == IDX_ACCEL_RECORD)
      begin
        if (obj_req.subindex == SUB_COUNT)
        begin
          next_state.rsp.rdata = LAST_SUB_INDEX;
          next_state.rsp.error = obj_req.write;
        end
        else if (obj_req.subindex == SUB_FIRST)
        begin
          next_state.rsp.rdata = state.accel_delta_speed;
          if (obj_req.write)
          begin
            next_state.accel_delta_speed = obj_req.wdata;
          end
        end
        else if (obj_req.subindex == SUB_SECOND)
        begin
          next_state.rsp.rdata = state.accel_delta_time;
          if (obj_req.write)
          begin
            next_state.accel_delta_time = obj_req.wdata;
          end
        end
        else
        begin
          next_state.rsp.error = 1'b1;
        end
      end
      else
      begin
        next_state.rsp.error = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state                        <= '0;
      state.control_word           <= CONTROL_WORD_RESET;
      state.target_speed_reference <= TARGET_SPEED_RESET;
      state.speed_limit_minimum    <= SPEED_MIN_RESET;
      state.speed_limit_maximum    <= SPEED_MAX_RESET;
      state.accel_delta_speed      <= DELTA_SPEED_RESET;
      state.accel_delta_time       <= DELTA_TIME_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign obj_rsp                = state.rsp;
  assign can_control_param_word = state.param_word;
  assign can_speed_ref_param    = state.speed_ref;
  assign ramped_speed_demand    = state.demand;
  assign status_mode_bits       = MODE_STATUS_BITS;

endmodule // vmr_velocity_mode

// File: verif/test_velocity_mode_ramp_objects.sv
// Self-checking bench for the velocity-mode object block.
`timescale 1ns/1ps
module test_velocity_mode_ramp_objects;
  import vmr_pkg::*;
  logic        sys_clk;
  logic        reset = 1'b1;
  vmr_req_t    obj_req;
  vmr_rsp_t    obj_rsp;
  vmr_rsp_t    rsp;
  logic [15:0] motor_speed_param = 16'h0000;
  logic        speed_feedback_present = 1'b0;
  logic [15:0] can_control_param_word;
  logic [15:0] can_speed_ref_param;
  logic [15:0] ramped_speed_demand;
  logic [1:0]  status_mode_bits;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          seed = 32'he363c2f2;
  vmr_velocity_mode #(.TICK_CYCLES(4)) uut (
    .sys_clk(sys_clk), .reset(reset), .obj_req(obj_req), .obj_rsp(obj_rsp),
    .motor_speed_param(motor_speed_param),
    .speed_feedback_present(speed_feedback_present),
    .can_control_param_word(can_control_param_word),
    .can_speed_ref_param(can_speed_ref_param),
    .ramped_speed_demand(ramped_speed_demand),
    .status_mode_bits(status_mode_bits));
  vmr_master_model m (.sys_clk(sys_clk), .obj_rsp(obj_rsp), .obj_req(obj_req));
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      print_verdict;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic acc(input logic wr, input logic [15:0] idx,
                     input logic [7:0] sub, input logic [31:0] wd,
                     input logic err);
    m.xfer(wr, idx, sub, wd, rsp);
    chk({30'h0, rsp.ack, rsp.error}, {30'h0, 1'b1, err});
  endtask
  task automatic cw(input logic [15:0] v, input logic en);
    acc(1'b1, 16'h6040, 8'h00, {16'h0000, v}, 1'b0);
    @(negedge sys_clk);
    chk({31'h0, can_control_param_word[0]}, {31'h0, en});
  endtask
  task automatic wait_dem(input logic [15:0] exp, output int n);
    n = 0;
    while (ramped_speed_demand !== exp && n < 2000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk({16'h0000, ramped_speed_demand}, {16'h0000, exp});
  endtask
  function automatic logic [15:0] goal(input logic [15:0] t, lo, hi);
    logic [15:0] mag;
    mag = t[15] ? -t : t;
    if (mag > hi)
      mag = hi;
    if (mag < lo)
      mag = lo;
    return t[15] ? -mag : mag;
  endfunction
  function automatic logic [31:0] sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction
  logic [15:0] ri [8] = '{16'h6040, 16'h6042, 16'h6046, 16'h6046,
                          16'h6046, 16'h6048, 16'h6048, 16'h6048};
  logic [7:0]  rs [8] = '{8'h0, 8'h0, 8'h0, 8'h1, 8'h2, 8'h0, 8'h1, 8'h2};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h7fff, 32'h2,
                          32'h1, 32'h1};
  logic [15:0] tg [3] = '{16'hffce, 16'h01f4, 16'h0003};
  initial
  begin
    int n;
    logic [15:0] t;
    logic [15:0] prev;
    logic [15:0] g;
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      m.xfer(1'b0, ri[i], rs[i], 32'h0, rsp);
      chk(rsp.rdata, rv[i]);
    end
    acc(1'b0, 16'h6045, 8'h00, 32'h0, 1'b1);
    acc(1'b1, 16'h6043, 8'h00, 32'h1, 1'b1);
    acc(1'b1, 16'h6044, 8'h00, 32'h1, 1'b1);
    acc(1'b1, 16'h6046, 8'h00, 32'h3, 1'b1);
    acc(1'b1, 16'h6048, 8'h00, 32'h3, 1'b1);
    acc(1'b1, 16'h6046, 8'h01, 32'h0, 1'b1);
    acc(1'b1, 16'h6046, 8'h02, 32'h8000_0064, 1'b1);
    acc(1'b0, 16'h6046, 8'h02, 32'h0, 1'b0);
    chk(rsp.rdata, 32'h7fff);
    prev = 16'h0000;
    for (int i = 0; i < 6; i++)
    begin
      t = 16'($random(seed));
      acc(1'b1, 16'h6042, 8'h00, {16'h0000, t}, 1'b0);
      chk(rsp.rdata, sx(prev));
      prev = t;
    end
    // Limits 10..100 rpm; 3 rpm per tick keeps the rate in range.
    acc(1'b1, 16'h6046, 8'h01, 32'h000a, 1'b0);
    acc(1'b1, 16'h6046, 8'h02, 32'h0064, 1'b0);
    acc(1'b1, 16'h6048, 8'h01, 32'h0003, 1'b0);
    acc(1'b1, 16'h6048, 8'h02, 32'h0001, 1'b0);
    acc(1'b1, 16'h6042, 8'h00, 32'h001e, 1'b0);
    cw(16'h0050, 1'b1);
    wait_dem(16'h001e, n);
    chk({31'h0, n inside {[30:48]}}, 32'h1);
    acc(1'b1, 16'h6048, 8'h01, 32'h0001, 1'b0);
    foreach (tg[i])
    begin
      acc(1'b1, 16'h6042, 8'h00, {16'h0000, tg[i]}, 1'b0);
      g = goal(tg[i], 16'h000a, 16'h0064);
      wait_dem(g, n);
      chk(can_control_param_word, {13'h0, tg[i][15], 2'b01});
      chk(can_speed_ref_param, 16'(g[15] ? -g : g));
      acc(1'b0, 16'h6043, 8'h00, 32'h0, 1'b0);
      chk(rsp.rdata, sx(g));
      speed_feedback_present = i[0];
      motor_speed_param = 16'($random(seed));
      acc(1'b0, 16'h6044, 8'h00, 32'h0, 1'b0);
      chk(rsp.rdata, sx(i[0] ? motor_speed_param : g));
    end
    cw(16'h0150, 1'b0);
    wait_dem(16'h0000, n);
    cw(16'h0070, 1'b1);
    wait_dem(16'h000a, n);
    cw(16'h0030, 1'b0);
    wait_dem(16'h0000, n);
    print_verdict;
  end
endmodule // test_velocity_mode_ramp_objects

// File: verif/vmr_master_model.sv
// Network master model issuing object accesses to the block.
`timescale 1ns/1ps
module vmr_master_model
(
  input  wire logic              sys_clk,
  input  wire vmr_pkg::vmr_rsp_t obj_rsp,
  output      vmr_pkg::vmr_req_t obj_req
);
  import vmr_pkg::*;
  initial obj_req = '0;
  // Released fields are inverted so a stale request is never reused.
  task automatic xfer(input logic wr, input logic [15:0] idx,
                      input logic [7:0] sub, input logic [31:0] wd,
                      output vmr_rsp_t rsp);
    int n;
    @(negedge sys_clk);
    obj_req = '{1'b1, wr, idx, sub, wd};
    @(negedge sys_clk);
    obj_req = '{1'b0, ~wr, ~idx, ~sub, ~wd};
    n = 0;
    while (obj_rsp.ack !== 1'b1 && n < 4)
    begin
      @(negedge sys_clk);
      n++;
    end
    rsp = obj_rsp;
  endtask
endmodule // vmr_master_model

// File: verif/vmr_velocity_mode_checker.sv
// Port assertions for the velocity-mode object block.
`timescale 1ns/1ps
module vmr_velocity_mode_checker
(
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire vmr_pkg::vmr_req_t obj_req,
  input wire vmr_pkg::vmr_rsp_t obj_rsp,
  input wire logic [15:0]       motor_speed_param,
  input wire logic              speed_feedback_present,
  input wire logic [15:0]       can_control_param_word,
  input wire logic [15:0]       ramped_speed_demand,
  input wire logic [1:0]        status_mode_bits
);
  import vmr_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  function automatic logic [31:0] sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction
  sequence s_rd(logic [15:0] idx);
    obj_req.valid && !obj_req.write && obj_req.index == idx
      && obj_req.subindex == SUB_COUNT;
  endsequence
  sequence s_wr(logic [15:0] idx);
    obj_req.valid && obj_req.write && obj_req.index == idx;
  endsequence
  property p_ack;
    obj_req.valid |=> obj_rsp.ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("access not answered");
  property p_quiet;
    !obj_req.valid |=> !obj_rsp.ack;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("answer without access");
  property p_status;
    status_mode_bits == 2'b00;
  endproperty
  a_status: assert property (p_status)
    else $error("mode status bits not zero");
  property p_cnt_lim;
    s_rd(IDX_SPEED_LIMITS) |=> !obj_rsp.error && obj_rsp.rdata == 32'h2;
  endproperty
  a_cnt_lim: assert property (p_cnt_lim)
    else $error("limit array count wrong");
  property p_cnt_acc;
    s_rd(IDX_ACCEL_RECORD) |=> !obj_rsp.error && obj_rsp.rdata == 32'h2;
  endproperty
  a_cnt_acc: assert property (p_cnt_acc)
    else $error("accel record count wrong");
  property p_ro;
    obj_req.valid && obj_req.write && (obj_req.index == IDX_RAMPED_DEMAND
      || obj_req.index == IDX_MEASURED_SPEED) |=> obj_rsp.error;
  endproperty
  a_ro: assert property (p_ro)
    else $error("read-only write not refused");
  property p_effort;
    s_rd(IDX_MEASURED_SPEED) |=> obj_rsp.rdata == sx($past(
      speed_feedback_present) ? $past(motor_speed_param)
      : $past(ramped_speed_demand));
  endproperty
  a_effort: assert property (p_effort)
    else $error("measured speed readback wrong");
  property p_ramp_bit;
    s_wr(IDX_CONTROL_WORD) ##0 obj_req.subindex == SUB_COUNT |=> ##1
      can_control_param_word[CP_RAMP_ENABLE] == ($past(obj_req.wdata[
      CW_REF_RAMP], 2) && !$past(obj_req.wdata[CW_HALT], 2));
  endproperty
  a_ramp_bit: assert property (p_ramp_bit)
    else $error("ramp enable bit wrong");
  property p_step;
    (ramped_speed_demand - $past(ramped_speed_demand))
      inside {16'h0000, 16'h0001, 16'hffff};
  endproperty
  a_step: assert property (p_step)
    else $error("demand jumped");
endmodule // vmr_velocity_mode_checker
bind vmr_velocity_mode vmr_velocity_mode_checker u_chk (
  .sys_clk(sys_clk), .reset(reset), .obj_req(obj_req), .obj_rsp(obj_rsp),
  .motor_speed_param(motor_speed_param),
  .speed_feedback_present(speed_feedback_present),
  .can_control_param_word(can_control_param_word),
  .ramped_speed_demand(ramped_speed_demand),
  .status_mode_bits(status_mode_bits));
